// ===== hw/oc_protect_regs.vh
// register map, field layout, reset values and timing constants of the over-current protection block
// Summary of operation
// RULE1: fault only when current strictly exceeds threshold
// RULE2: host writes fault threshold, exponent minus two
// RULE3: delay field bits 2:0, 200 ms steps
// RULE4: status fault bit set for every response
// RULE5: host notified on fault for every response
// RULE6: code 00 runs on, constant-current limiting
// RULE7: code 11 disables output, then retry policy
// RULE8: retry 000 means stay off until cleared
// RULE9: retry 001..110 tries that many, then off
// RULE10: retry 111 retries until off or other fault
// RULE11: interval counted start to start of attempts
// RULE12: host writes warning threshold, exponent minus two
// RULE13: warning exceed may also shut output down
// RULE14: codes 01 and 10 act like code 11
`ifndef OC_PROTECT_REGS_VH
`define OC_PROTECT_REGS_VH

// command codes of the three registers
`define OC_FAULT_THR_ADDR 8'h46
`define OC_ACTION_ADDR 8'h47
`define OC_WARN_THR_ADDR 8'h4a

// reset values (exponent field 5'b11110 = minus two)
`define OC_FAULT_THR_RST 16'hf0a0
`define OC_ACTION_RST 8'hc0
`define OC_WARN_THR_RST 16'hf080

// linear format: mantissa field
`define LIN_MANT_MSB 10
`define LIN_MANT_LSB 0

// action register fields
`define ACT_DELAY_MSB 2
`define ACT_DELAY_LSB 0
`define ACT_RETRY_MSB 5
`define ACT_RETRY_LSB 3
`define ACT_RESP_MSB 7
`define ACT_RESP_LSB 6

// response and retry codes
`define RESP_CC_LIMIT 2'h0
`define RETRY_NONE 3'h0
`define RETRY_FOREVER 3'h7

// timing: one delay step and the clock rate
`define OC_STEP_MS 200
`define CLK_KHZ 100000
`define OC_STEP_CYCLES (`OC_STEP_MS * `CLK_KHZ)

`endif

// ===== hw/oc_retry_timer.v
// restart interval timer: counts a number of delay steps from a start pulse
`default_nettype none
`include "oc_protect_regs.vh"

module oc_retry_timer #(
    parameter STEP_CYCLES = `OC_STEP_CYCLES // clock cycles in one delay step
) (
    input wire i_clk_sys, // system clock
    input wire i_rst_b, // async reset, active low
    input wire i_start, // pulse: restart the interval
    input wire [2:0] i_steps, // interval length in steps
    output reg o_expired // pulse: interval over
);
    reg [31:0] cyc_cnt; // cycles within the current step
    reg [2:0] step_cnt; // steps left
    reg running; // interval in progress

    // a zero step count ends the interval one cycle after the start
    always @(posedge i_clk_sys or negedge i_rst_b) begin
        if (!i_rst_b) begin
            cyc_cnt <= 32'h0;
            step_cnt <= 3'h0;
            running <= 1'b0;
            o_expired <= 1'b0;
        end else begin
            o_expired <= 1'b0;
            if (i_start) begin // new attempt restarts the count [RULE11]
                cyc_cnt <= 32'h0;
                step_cnt <= i_steps; // [RULE3]
                running <= 1'b1;
            end else if (running) begin
                if (step_cnt == 3'h0) begin // all steps done
                    running <= 1'b0;
                    o_expired <= 1'b1;
                end else if (cyc_cnt == STEP_CYCLES - 1) begin
                    cyc_cnt <= 32'h0;
                    step_cnt <= step_cnt - 3'h1;
                end else begin
                    cyc_cnt <= cyc_cnt + 32'h1;
                end
            end
        end
    end
endmodule
`default_nettype wire

// ===== hw/oc_protect.v
// output over-current protection: thresholds, fault response and restart policy
`default_nettype none
`include "oc_protect_regs.vh"

module oc_protect #(
    parameter STEP_CYCLES = `OC_STEP_CYCLES // cycles per 200 ms step, shorten in simulation
) (
    input wire i_clk_sys, // system clock, 100 MHz
    input wire i_rst_b, // async reset, active low (bias loss)
    input wire i_reg_wr, // pulse: register write
    input wire i_reg_rd, // pulse: register read
    input wire [7:0] i_reg_cmd, // register command code
    input wire [15:0] i_reg_wdata, // write data
    output reg [15:0] o_reg_rdata, // read data, one cycle after read
    input wire [15:0] i_iout_meas, // measured output current, linear exp -2
    input wire i_ctrl_pin, // on/off pin, asynchronous
    input wire i_operation_on, // on/off command, same clock
    input wire i_other_fault, // another fault forces shutdown
    input wire i_fault_clear, // pulse: clear status and latched fault
    input wire i_warn_trip_en, // warning exceed also shuts down
    output reg o_output_enable, // converter output enabled
    output reg o_cc_limit, // hold current at fault threshold
    output reg o_status_oc_fault, // sticky over-current fault bit
    output reg o_status_oc_warn, // sticky over-current warning bit
    output reg o_host_alert // host notification, level
);
    localparam ST_IDLE = 2'h0; // commanded off
    localparam ST_RUN = 2'h1; // output on
    localparam ST_RETRY = 2'h2; // restart sequence running
    localparam ST_LATCH = 2'h3; // off until fault cleared

    reg [15:0] overcurrent_fault_threshold; // fault limit
    reg [7:0] overcurrent_fault_action; // response, retries, delay
    reg [15:0] overcurrent_warning_threshold; // warning limit
    reg [1:0] state; // protection state
    reg [1:0] next_state; // next protection state
    reg [2:0] attempts; // restart attempts made
    reg [2:0] next_attempts; // next attempt count
    reg failed; // current interval saw the fault again
    reg next_failed; // next failed flag
    reg next_output_enable; // next output enable
    reg next_cc_limit; // next limiter request
    reg timer_start; // pulse: begin a restart interval
    reg ctrl_s1, ctrl_s2, ctrl_s3; // pin synchroniser
    reg ctrl_on; // filtered pin level
    wire timer_expired; // interval over
    wire oc_trip; // fault threshold exceeded
    wire warn_trip; // warning threshold exceeded
    wire run_cmd; // output commanded on
    wire [1:0] resp; // response field
    wire [2:0] retries; // retry field

    // strict signed compare of linear mantissas; exponents assumed equal
    function above;
        input [15:0] meas;
        input [15:0] limit;
        begin
            above = $signed(meas[`LIN_MANT_MSB:`LIN_MANT_LSB]) > $signed(limit[`LIN_MANT_MSB:`LIN_MANT_LSB]);
        end
    endfunction

    // equality never trips, so the limit resolution sets the trip point
    assign oc_trip = above(i_iout_meas, overcurrent_fault_threshold); // [RULE1] [RULE2]
    assign warn_trip = above(i_iout_meas, overcurrent_warning_threshold); // [RULE12]
    assign run_cmd = ctrl_on & i_operation_on;
    assign resp = overcurrent_fault_action[`ACT_RESP_MSB:`ACT_RESP_LSB];
    assign retries = overcurrent_fault_action[`ACT_RETRY_MSB:`ACT_RETRY_LSB];

    // pin synchroniser: level accepted once stages two and three agree
    always @(posedge i_clk_sys or negedge i_rst_b) begin
        if (!i_rst_b) begin
            ctrl_s1 <= 1'b0;
            ctrl_s2 <= 1'b0;
            ctrl_s3 <= 1'b0;
            ctrl_on <= 1'b0;
        end else begin
            ctrl_s1 <= i_ctrl_pin;
            ctrl_s2 <= ctrl_s1;
            ctrl_s3 <= ctrl_s2;
            if (ctrl_s2 == ctrl_s3) begin
                ctrl_on <= ctrl_s3;
            end
        end
    end

    // register writes and reads by command code
    always @(posedge i_clk_sys or negedge i_rst_b) begin
        if (!i_rst_b) begin
            overcurrent_fault_threshold <= `OC_FAULT_THR_RST;
            overcurrent_fault_action <= `OC_ACTION_RST;
            overcurrent_warning_threshold <= `OC_WARN_THR_RST;
            o_reg_rdata <= 16'h0000;
        end else begin
            if (i_reg_wr) begin
                case (i_reg_cmd)
                    `OC_FAULT_THR_ADDR: overcurrent_fault_threshold <= i_reg_wdata;
                    `OC_ACTION_ADDR: overcurrent_fault_action <= i_reg_wdata[7:0];
                    `OC_WARN_THR_ADDR: overcurrent_warning_threshold <= i_reg_wdata;
                    default: ; // unknown codes ignored
                endcase
            end
            if (i_reg_rd) begin
                case (i_reg_cmd)
                    `OC_FAULT_THR_ADDR: o_reg_rdata <= overcurrent_fault_threshold;
                    `OC_ACTION_ADDR: o_reg_rdata <= {8'h00, overcurrent_fault_action};
                    `OC_WARN_THR_ADDR: o_reg_rdata <= overcurrent_warning_threshold;
                    default: o_reg_rdata <= 16'h0000; // unmapped reads zero
                endcase
            end
        end
    end

    // status bits: a trip in the clear cycle still sets the bit
    always @(posedge i_clk_sys or negedge i_rst_b) begin
        if (!i_rst_b) begin
            o_status_oc_fault <= 1'b0;
            o_status_oc_warn <= 1'b0;
            o_host_alert <= 1'b0;
        end else begin
            o_status_oc_fault <= oc_trip | (o_status_oc_fault & ~i_fault_clear); // [RULE4]
            o_status_oc_warn <= warn_trip | (o_status_oc_warn & ~i_fault_clear);
            // alert follows the sticky bits whatever the response code
            o_host_alert <= oc_trip | warn_trip | ((o_status_oc_fault | o_status_oc_warn) & ~i_fault_clear); // [RULE5]
        end
    end

    // protection state machine, next values
    always @* begin
        next_state = state;
        next_attempts = attempts;
        next_failed = failed;
        next_output_enable = o_output_enable;
        next_cc_limit = 1'b0;
        timer_start = 1'b0;
        if (i_other_fault) begin // another fault ends every retry [RULE10]
            next_state = ST_LATCH;
            next_output_enable = 1'b0;
        end else begin
            case (state)
                ST_IDLE: begin
                    next_output_enable = 1'b0;
                    if (run_cmd) begin
                        next_state = ST_RUN;
                        next_output_enable = 1'b1;
                    end
                end
                ST_RUN: begin
                    if (!run_cmd) begin
                        next_state = ST_IDLE;
                        next_output_enable = 1'b0;
                    end else if (oc_trip && resp == `RESP_CC_LIMIT) begin
                        next_cc_limit = 1'b1; // stay on, limit the current [RULE6]
                    end else if (oc_trip || (warn_trip && i_warn_trip_en)) begin // [RULE13]
                        // codes 01, 10 and 11 all shut down [RULE7] [RULE14]
                        next_output_enable = 1'b0;
                        next_attempts = 3'h0;
                        next_failed = 1'b1;
                        if (retries == `RETRY_NONE) begin
                            next_state = ST_LATCH; // [RULE8]
                        end else begin
                            next_state = ST_RETRY;
                            timer_start = 1'b1;
                        end
                    end
                end
                ST_RETRY: begin
                    if (!run_cmd) begin // commanded off stops retrying [RULE10]
                        next_state = ST_IDLE;
                        next_output_enable = 1'b0;
                    end else if (o_output_enable && oc_trip) begin
                        // attempt failed; wait out the interval off
                        next_output_enable = 1'b0;
                        next_failed = 1'b1;
                        // a trip on the expiry cycle would swallow the pulse and stall the sequence
                        timer_start = timer_expired;
                    end else if (timer_expired) begin
                        if (!failed) begin
                            next_state = ST_RUN; // attempt held a full interval
                        end else if (retries == `RETRY_FOREVER || attempts < retries) begin // [RULE9] [RULE10]
                            next_attempts = (attempts == 3'h7) ? attempts : attempts + 3'h1;
                            next_output_enable = 1'b1;
                            next_failed = 1'b0;
                            timer_start = 1'b1; // interval starts with the attempt [RULE11]
                        end else begin
                            next_state = ST_LATCH; // attempts used up [RULE9]
                        end
                    end
                end
                ST_LATCH: begin
                    next_output_enable = 1'b0;
                    if (i_fault_clear) begin
                        next_state = ST_IDLE; // [RULE8]
                    end
                end
                default: begin
                    next_state = ST_IDLE;
                    next_output_enable = 1'b0;
                end
            endcase
        end
    end

    // protection state registers
    always @(posedge i_clk_sys or negedge i_rst_b) begin
        if (!i_rst_b) begin
            state <= ST_IDLE;
            attempts <= 3'h0;
            failed <= 1'b0;
            o_output_enable <= 1'b0;
            o_cc_limit <= 1'b0;
        end else begin
            state <= next_state;
            attempts <= next_attempts;
            failed <= next_failed;
            o_output_enable <= next_output_enable;
            o_cc_limit <= next_cc_limit;
        end
    end

    // restart interval timer, delay taken from the action register
    oc_retry_timer #(
        .STEP_CYCLES(STEP_CYCLES)
    ) u_timer (
        .i_clk_sys(i_clk_sys),
        .i_rst_b(i_rst_b),
        .i_start(timer_start),
        .i_steps(overcurrent_fault_action[`ACT_DELAY_MSB:`ACT_DELAY_LSB]), // [RULE3]
        .o_expired(timer_expired)
    );
endmodule
`default_nettype wire

// ===== verif/oc_protect_assertions.sv
// concurrent checks on the protection block ports
`default_nettype none
`include "oc_protect_regs.vh"
module oc_protect_assertions #(
    parameter STEP_CYCLES = 10 // cycles per delay step
) (
    input wire logic i_clk_sys, // clock
    input wire logic i_rst_b, // reset, low
    input wire logic i_reg_wr, // write strobe
    input wire logic [7:0] i_reg_cmd, // command
    input wire logic [15:0] i_reg_wdata, // write data
    input wire logic [15:0] i_iout_meas, // current
    input wire logic i_operation_on, // on command
    input wire logic i_fault_clear, // clear pulse
    input wire logic i_warn_trip_en, // warn shutdown
    input wire logic o_output_enable, // output on
    input wire logic o_cc_limit, // limiting
    input wire logic o_status_oc_fault, // fault bit
    input wire logic o_host_alert // alert
);
    timeunit 1ns;
    timeprecision 100ps;
    logic [15:0] thr; // shadow fault threshold
    logic [7:0] act; // shadow action
    logic latched; // lockout after retry 000
    logic trip; // strictly above threshold
    logic shut; // shutdown response set
    // signed mantissas, so equality never trips
    assign trip = $signed(i_iout_meas[10:0]) > $signed(thr[10:0]);
    assign shut = act[7:6] != `RESP_CC_LIMIT;
    // shadows follow host writes
    always_ff @(posedge i_clk_sys or negedge i_rst_b) begin
        if (!i_rst_b) begin
            thr <= `OC_FAULT_THR_RST;
            act <= `OC_ACTION_RST;
            latched <= 1'b0;
        end else begin
            if (i_reg_wr && i_reg_cmd == `OC_FAULT_THR_ADDR) thr <= i_reg_wdata;
            if (i_reg_wr && i_reg_cmd == `OC_ACTION_ADDR) act <= i_reg_wdata[7:0];
            if (i_fault_clear) latched <= 1'b0;
            else if (trip && shut && act[5:3] == `RETRY_NONE && o_output_enable) latched <= 1'b1;
        end
    end
    default clocking cb @(posedge i_clk_sys); endclocking
    default disable iff (!i_rst_b);
    property p_fault_set; trip |=> o_status_oc_fault; endproperty
    a_fault_set: assert property (p_fault_set) else $error("fault bit missed a trip");
    property p_fault_cause; $rose(o_status_oc_fault) |-> $past(trip); endproperty
    a_fault_cause: assert property (p_fault_cause) else $error("fault bit without trip");
    property p_alert; trip |=> o_host_alert; endproperty
    a_alert: assert property (p_alert) else $error("no host alert on trip");
    property p_cc; trip && !shut && o_output_enable && i_operation_on && !i_warn_trip_en |=> o_cc_limit && o_output_enable; endproperty
    a_cc: assert property (p_cc) else $error("limiting not entered");
    property p_cc_drop; !trip |=> !o_cc_limit; endproperty
    a_cc_drop: assert property (p_cc_drop) else $error("limiting without trip");
    property p_shut; trip && shut && o_output_enable |=> !o_output_enable; endproperty
    a_shut: assert property (p_shut) else $error("output not disabled");
    property p_latch; latched |-> !o_output_enable; endproperty
    a_latch: assert property (p_latch) else $error("restart despite no retry");
    property p_off; !i_operation_on |=> !o_output_enable; endproperty
    a_off: assert property (p_off) else $error("output on while commanded off");
    c_limit: cover property (trip && !shut ##1 o_cc_limit);
    c_retry: cover property ($fell(o_output_enable) ##[2:100] $rose(o_output_enable));
    c_lock: cover property ($rose(latched));
endmodule
`default_nettype wire

// ===== verif/oc_host_model.sv
// host model: management side of the register port
`default_nettype none
module oc_host_model (
    input wire logic i_clk_sys, // clock
    input wire logic [15:0] i_reg_rdata, // read data
    output logic o_reg_wr, // write strobe
    output logic o_reg_rd, // read strobe
    output logic [7:0] o_reg_cmd, // command
    output logic [15:0] o_reg_wdata // write data
);
    timeunit 1ns;
    timeprecision 100ps;
    // bus idle from time zero
    initial begin
        o_reg_wr = 1'b0;
        o_reg_rd = 1'b0;
        o_reg_cmd = 8'h00;
        o_reg_wdata = 16'h0000;
    end
    // quarter amperes as a linear word, exponent held at minus two
    function automatic logic [15:0] lin(input logic [10:0] m);
        return {5'b11110, m};
    endfunction
    // one access over exactly one edge; afterwards the bus is scrambled, not held
    task automatic xfer(input logic w, input logic [7:0] c, input logic [15:0] dw, output logic [15:0] dr);
        @(posedge i_clk_sys);
        #1;
        o_reg_wr = w;
        o_reg_rd = !w;
        o_reg_cmd = c;
        o_reg_wdata = dw;
        @(posedge i_clk_sys);
        #1;
        o_reg_wr = 1'b0;
        o_reg_rd = 1'b0;
        o_reg_cmd = ~c;
        o_reg_wdata = ~dw;
        dr = i_reg_rdata;
    endtask
endmodule
`default_nettype wire

// ===== verif/overcurrent_fault_retry_bench.sv
// self-checking bench for the over-current protection block
`default_nettype none
`include "oc_protect_regs.vh"
module overcurrent_fault_retry_bench;
    timeunit 1ns;
    timeprecision 100ps;
    localparam int STEP = 10; // short step keeps the run brief
    logic clk, rst_b, wr, rd, op_on, clr, wen, en, cc, st_f, st_w, alert; // bench nets
    logic pin, oth; // on/off pin, other fault
    logic [7:0] cmd; // command
    logic [15:0] wdata, rdata, meas, d; // bus, current, read value
    int error_cnt = 0; // mismatches
    int comparisons = 0; // checks made
    int r, g, g1; // restarts and gaps
    // 100 MHz clock
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    oc_host_model i_host (.i_clk_sys(clk), .i_reg_rdata(rdata), .o_reg_wr(wr), .o_reg_rd(rd), .o_reg_cmd(cmd),
        .o_reg_wdata(wdata));
    oc_protect #(.STEP_CYCLES(STEP)) i_dut (.i_clk_sys(clk), .i_rst_b(rst_b), .i_reg_wr(wr), .i_reg_rd(rd),
        .i_reg_cmd(cmd), .i_reg_wdata(wdata), .o_reg_rdata(rdata), .i_iout_meas(meas), .i_ctrl_pin(pin),
        .i_operation_on(op_on), .i_other_fault(oth), .i_fault_clear(clr), .i_warn_trip_en(wen),
        .o_output_enable(en), .o_cc_limit(cc), .o_status_oc_fault(st_f), .o_status_oc_warn(st_w),
        .o_host_alert(alert));
    // compare, count, report
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        comparisons++;
        if (got !== exp) begin
            error_cnt++;
            $display("ERROR %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    // verdict and end of run
    task automatic stop_test();
        $display("errors %0d comparisons %0d", error_cnt, comparisons);
        if (error_cnt == 0 && comparisons > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask
    // n edges, then step clear of the edge
    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    // read one register and compare
    task automatic rdchk(input logic [7:0] c, input logic [15:0] e);
        i_host.xfer(1'b0, c, 16'h0000, d);
        chk(d, e);
    endtask
    // count output restarts over n cycles, gap between first two
    task automatic watch(input int n);
        logic p;
        p = en;
        r = 0;
        for (int t = 1; t <= n; t++) begin
            cyc(1);
            if (en === 1'b1 && p === 1'b0) begin
                r++;
                g = (r == 1) ? t : (r == 2) ? t - g : g;
            end
            p = en;
        end
    endtask
    // program an action and hold an over-current
    task automatic run_fault(input logic [7:0] a);
        i_host.xfer(1'b1, `OC_ACTION_ADDR, {8'h00, a}, d);
        meas = i_host.lin(11'd101);
        watch(200);
    endtask
    // off command must stop restarts; then clear and bring output back
    task automatic recover();
        op_on = 1'b0;
        watch(30);
        chk(r, 0);
        meas = 16'hf000;
        clr = 1'b1;
        cyc(1);
        clr = 1'b0;
        op_on = 1'b1;
        repeat (20) if (en !== 1'b1) cyc(1);
        chk(en, 1'b1);
        if (en !== 1'b1) stop_test();
    endtask
    // reset, then scenarios
    initial begin
        rst_b = 1'b0;
        op_on = 1'b1;
        pin = 1'b1;
        oth = 1'b0;
        clr = 1'b0;
        wen = 1'b0;
        meas = 16'hf000;
        cyc(2);
        rst_b = 1'b1;
        rdchk(`OC_FAULT_THR_ADDR, 16'hf0a0);
        rdchk(`OC_ACTION_ADDR, 16'h00c0);
        rdchk(`OC_WARN_THR_ADDR, 16'hf080);
        rdchk(8'h00, 16'h0000);
        i_host.xfer(1'b1, `OC_FAULT_THR_ADDR, i_host.lin(11'd100), d);
        rdchk(`OC_FAULT_THR_ADDR, 16'hf064);
        // equal current holds, one count above trips; action reset is no retry
        meas = i_host.lin(11'd100);
        cyc(8);
        chk({st_f, en}, 2'b01);
        meas = i_host.lin(11'd101);
        cyc(1);
        chk({st_f, alert, en}, 3'b110);
        cyc(40);
        chk(en, 1'b0);
        recover();
        // retry counts one to six, then codes 01 and 10 with two retries
        for (int k = 0; k < 8; k++) begin
            run_fault({k < 6 ? 2'b11 : 2'(k - 5), k < 6 ? 3'(k + 1) : 3'd2, 3'd1});
            chk(r, k < 6 ? k + 1 : 2);
            recover();
        end
        // unlimited retry, delay one step then three steps
        run_fault(8'hf9);
        g1 = g;
        chk(r > 9, 1'b1);
        // pin off stops the unlimited retry
        pin = 1'b0;
        cyc(6);
        watch(30);
        chk(r, 0);
        chk(en, 1'b0);
        pin = 1'b1;
        recover();
        // another fault ends the unlimited retry until cleared
        run_fault(8'hf9);
        oth = 1'b1;
        cyc(1);
        oth = 1'b0;
        watch(30);
        chk(r, 0);
        chk(en, 1'b0);
        recover();
        run_fault(8'hfb);
        chk(g - g1, 2 * STEP);
        recover();
        // code 00 limits current and keeps running
        run_fault(8'h00);
        chk({cc, en, st_f, alert, r[0]}, 5'h1e);
        meas = 16'hf000;
        cyc(1);
        chk(cc, 1'b0);
        recover();
        // warning exceed shuts down only when enabled
        i_host.xfer(1'b1, `OC_WARN_THR_ADDR, i_host.lin(11'd90), d);
        meas = i_host.lin(11'd95);
        cyc(5);
        chk({st_w, en}, 2'b11);
        wen = 1'b1;
        cyc(1);
        chk(en, 1'b0);
        wen = 1'b0;
        recover();
        // bias loss in mid-retry: output, fault status and alert off, fault threshold and action back to reset
        run_fault(8'hf9);
        rst_b = 1'b0;
        cyc(2);
        rst_b = 1'b1;
        chk({en, st_f, alert}, 3'b000);
        rdchk(`OC_FAULT_THR_ADDR, 16'hf0a0);
        rdchk(`OC_ACTION_ADDR, 16'h00c0);
        stop_test();
    end
endmodule
bind oc_protect oc_protect_assertions #(.STEP_CYCLES(STEP_CYCLES)) i_chk (.i_clk_sys(i_clk_sys),
    .i_rst_b(i_rst_b), .i_reg_wr(i_reg_wr), .i_reg_cmd(i_reg_cmd), .i_reg_wdata(i_reg_wdata),
    .i_iout_meas(i_iout_meas), .i_operation_on(i_operation_on), .i_fault_clear(i_fault_clear),
    .i_warn_trip_en(i_warn_trip_en), .o_output_enable(o_output_enable), .o_cc_limit(o_cc_limit),
    .o_status_oc_fault(o_status_oc_fault), .o_host_alert(o_host_alert));
`default_nettype wire
